// ===== logic/sss_pkg.sv
// sync source selector: shared constants, encodings and carrier types
// assumes a 250 MHz core clock and a recovered link clock from the receivers
`default_nettype none
package sss_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_MHZ   = 250;
    localparam int MEAS_WIN_NS    = 1000000;
    localparam int MEAS_WIN_CYC   = MEAS_WIN_NS * CORE_CLK_MHZ / 1000;
    localparam int GUARD_NS       = 40;
    localparam int GUARD_CYC      = (GUARD_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int GUARD_W        = 4;
    localparam int FCNT_W         = 10;
    // ------------------------------------------------------------
    // sources: code 0 is the internal reference
    // ------------------------------------------------------------
    localparam int SRC_W          = 3;
    localparam int NUM_IN         = 6;
    localparam int NUM_STD_IN     = 4;
    localparam logic [2:0] SRC_INT   = 3'h0;
    localparam logic [2:0] SRC_WC    = 3'h1;
    localparam logic [2:0] SRC_OPT1  = 3'h2;
    localparam logic [2:0] SRC_OPT2  = 3'h3;
    localparam logic [2:0] SRC_SPDIF = 3'h4;
    localparam logic [2:0] SRC_TC    = 3'h5;
    localparam logic [2:0] SRC_VIDEO = 3'h6;
    localparam logic [1:0] ST_NOLOCK = 2'h0;
    localparam logic [1:0] ST_LOCK   = 2'h1;
    localparam logic [1:0] ST_SYNC   = 2'h2;
    // ------------------------------------------------------------
    // rates
    // ------------------------------------------------------------
    localparam logic [17:0] XTAL_44K1_HZ   = 18'h0AC44;
    localparam logic [17:0] XTAL_48K_HZ    = 18'h0BB80;
    localparam logic [20:0] PULL_SMALL_DIV = 21'h003E8;
    localparam logic [20:0] PULL_LARGE_DIV = 21'h00019;
    localparam logic [22:0] HZ_PER_KHZ     = 23'h003E8;
    localparam int CH_ALL       = 28;
    localparam int CH_NO_OPT2   = 20;
    localparam int CH_ANA_SPDIF = 12;
    localparam int CH_ANA8      = 8;
    typedef enum logic [1:0] {MULT_SINGLE = 2'h0, MULT_DOUBLE = 2'h1, MULT_QUAD = 2'h2}
        sss_mult_type;
    typedef enum logic [1:0] {BW_ALL = 2'h0, BW_NO_OPT2 = 2'h1, BW_ANA_SPDIF = 2'h2,
        BW_ANA8 = 2'h3} sss_bw_type;
    typedef enum logic [2:0] {PULL_NONE = 3'h0, PULL_UP_SMALL = 3'h1, PULL_DN_SMALL = 3'h2,
        PULL_UP_LARGE = 3'h3, PULL_DN_LARGE = 3'h4} sss_pull_type;
    typedef struct packed {
        logic                auto_mode;
        logic [2:0]          pref_src;
        sss_bw_type          bw;
        logic                fam_48k;
        sss_mult_type        mult;
        logic                dds_en;
        logic [17:0]         dds_base_hz;
        logic                coarse_en;
        logic signed [15:0]  coarse_hz;
        logic                fine_en;
        logic signed [15:0]  fine_hz;
        sss_pull_type        pull;
    } sss_cfg_type;
    localparam sss_cfg_type CFG_RESET = '0;
    typedef struct packed {
        logic [1:0] wc;
        logic [1:0] opt1;
        logic [1:0] opt2;
        logic [1:0] spdif;
    } sss_stat_type;
endpackage
`default_nettype wire

// ===== logic/sss_selector.sv
// sync source selector: reference choice, lock status, rate synthesis, bandwidth
// assumes receivers give lock/sync levels as async pins and a frame tick on link_clk
//
// Contract
// - auto mode watches every digital input continuously
// - valid input found: leave crystal, report slave
// - reference fails: revert to internal, report master
// - valid preferred input is the reference
// - else first valid input is the reference
// - no valid input: master on internal reference
// - report active input and its frequency
// - per input: no lock, lock or sync (reported for wc, opt1, opt2 and spdif only)
// - lock to any rate in range
// - double speed, optical preferred: sample multiplex
// - multiplexed optical frequency is half
// - synthesised rate only in master mode
// - rate from base, multiplier, active fader
// - faders enabled separately, one hertz steps
// - preset video pull-up and pull-down deviations
// - synthesiser enable gates all its settings
// - bandwidth default all; reduced drops optical two
// - analog plus spdif; analog first eight only
// - stored settings applied right after power-on
// - timecode and video only when module fitted
`timescale 1ns/100ps
`default_nettype none
module sss_selector #(
    parameter int MEAS_WIN = sss_pkg::MEAS_WIN_CYC
) (
    input  wire logic                  core_clk,       // core clock
    input  wire logic                  srst,           // sync reset, high
    input  wire logic                  link_clk,       // recovered reference clock
    input  wire logic                  frame_tick,     // one per frame, link domain
    input  wire logic [5:0]            in_lock,        // async lock per input
    input  wire logic [5:0]            in_sync,        // async sync per input
    input  wire logic                  tco_fitted,     // async module-present strap
    input  wire sss_pkg::sss_cfg_type  host_cfg,       // settings from software
    input  wire logic                  host_cfg_wr,    // take host_cfg
    input  wire sss_pkg::sss_cfg_type  nv_cfg,         // stored settings
    input  wire logic                  nv_ready,       // stored settings valid
    output logic [2:0]                 clk_sel,        // reference mux select
    output logic                       clk_gate_en,    // sample clock gate
    output logic                       slave,          // 1 slave, 0 master
    output logic [2:0]                 active_src,     // reported reference
    output logic [9:0]                 active_khz,     // reported frequency
    output sss_pkg::sss_stat_type      sync_stat,      // status of the four standard inputs
    output logic                       smux_mode,      // sample multiplex on
    output logic [9:0]                 opt_khz,        // optical frame rate
    output logic [21:0]                int_rate_hz,    // internal synth rate
    output logic [27:0]                chan_en         // active channels
);
    // ------------------------------------------------------------
    // link domain: gray frame counter
    // ------------------------------------------------------------
    logic                   lrst_meta_r;
    logic                   lrst_r;
    logic [9:0]             lbin_r;
    logic [9:0]             lgray_r;
    wire  logic [9:0]       lbin_nxt = lbin_r + 10'h001;

    // reset reaches the link side through two flops; the clock may stand still
    always_ff @(posedge link_clk) begin
        lrst_meta_r <= srst;
        lrst_r      <= lrst_meta_r;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_r) begin
            lbin_r  <= 10'h000;
            lgray_r <= 10'h000;
        end else if (frame_tick) begin
            lbin_r  <= lbin_nxt;
            lgray_r <= lbin_nxt ^ (lbin_nxt >> 1);
        end
    end

    // ------------------------------------------------------------
    // core domain: synchronisers
    // ------------------------------------------------------------
    logic [9:0]             gray_meta_r;
    logic [9:0]             gray_s_r;
    logic [5:0]             lock_meta_r;
    logic [5:0]             lock_s_r;
    logic [5:0]             sync_meta_r;
    logic [5:0]             sync_s_r;
    logic                   tco_meta_r;
    logic                   tco_s_r;

    always_ff @(posedge core_clk) begin
        gray_meta_r <= lgray_r;
        gray_s_r    <= gray_meta_r;
        lock_meta_r <= in_lock;
        lock_s_r    <= lock_meta_r;
        sync_meta_r <= in_sync;
        sync_s_r    <= sync_meta_r;
        tco_meta_r  <= tco_fitted;
        tco_s_r     <= tco_meta_r;
    end

    // ------------------------------------------------------------
    // settings: stored set once unless a host write comes first; host writes win
    // ------------------------------------------------------------
    sss_pkg::sss_cfg_type   cfg_r;
    logic                   nv_done_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_r     <= sss_pkg::CFG_RESET;
            nv_done_r <= 1'b0;
        end else if (host_cfg_wr) begin
            cfg_r     <= host_cfg;
            nv_done_r <= 1'b1;
        end else if (!nv_done_r && nv_ready) begin
            cfg_r     <= nv_cfg;
            nv_done_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // input validity and reference choice
    // ------------------------------------------------------------
    logic [5:0]             valid;
    genvar gi;
    generate
        for (gi = 0; gi < sss_pkg::NUM_IN; gi++) begin : g_valid
            if (gi < sss_pkg::NUM_STD_IN) begin : g_std
                assign valid[gi] = lock_s_r[gi];
            end else begin : g_opt
                assign valid[gi] = lock_s_r[gi] & tco_s_r;
            end
        end
    endgenerate

    // lowest-numbered valid input wins; code 0 means none
    function automatic logic [2:0] first_valid(input logic [5:0] v);
        logic [2:0] r;
        r = sss_pkg::SRC_INT;
        for (int i = sss_pkg::NUM_IN - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i + 1);
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] in_state(input logic l, input logic s);
        return !l ? sss_pkg::ST_NOLOCK : (s ? sss_pkg::ST_SYNC : sss_pkg::ST_LOCK);
    endfunction

    wire logic              pref_ok  = (cfg_r.pref_src != sss_pkg::SRC_INT) &&
                                       (cfg_r.pref_src <= 3'(sss_pkg::NUM_IN)) &&
                                       valid[cfg_r.pref_src - 3'h1];
    wire logic [2:0]        pick     = pref_ok ? cfg_r.pref_src
                                               : first_valid(valid);
    wire logic [2:0]        target   = cfg_r.auto_mode ? pick : sss_pkg::SRC_INT;

    // ------------------------------------------------------------
    // reference switch: break before make
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SW_MASTER = 3'b001,
        SW_GUARD  = 3'b010,
        SW_SLAVE  = 3'b100
    } sss_sw_type;

    sss_sw_type             sw_r;
    logic [2:0]             pend_r;
    logic [3:0]             guard_r;
    logic [2:0]             clk_sel_r;
    logic                   gate_r;

    wire logic              moved    = (target != clk_sel_r);
    wire logic              guard_end = (guard_r == 4'(sss_pkg::GUARD_CYC - 1));

    // the gate is shut for the whole guard and reopens on the same edge that the mux moves
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sw_r      <= SW_MASTER;
            pend_r    <= sss_pkg::SRC_INT;
            guard_r   <= 4'h0;
            clk_sel_r <= sss_pkg::SRC_INT;
            gate_r    <= 1'b1;
        end else begin
            unique case (sw_r)
                SW_MASTER, SW_SLAVE: begin
                    guard_r <= 4'h0;
                    if (moved) begin
                        sw_r   <= SW_GUARD;
                        pend_r <= target;
                        gate_r <= 1'b0;
                    end
                end
                SW_GUARD: begin
                    if (target != pend_r) begin
                        pend_r  <= target;
                        guard_r <= 4'h0;
                    end else if (guard_end) begin
                        clk_sel_r <= pend_r;
                        gate_r    <= 1'b1;
                        sw_r      <= (pend_r == sss_pkg::SRC_INT) ? SW_MASTER : SW_SLAVE;
                    end else begin
                        guard_r <= guard_r + 4'h1;
                    end
                end
            endcase
        end
    end

    wire logic              is_master = (clk_sel_r == sss_pkg::SRC_INT);

    // ------------------------------------------------------------
    // frequency of the active reference, frames per millisecond
    // ------------------------------------------------------------
    logic [19:0]            win_r;
    logic [9:0]             bin_prev_r;
    logic [9:0]             meas_khz_r;
    logic [9:0]             gray_bin;

    always_comb begin
        gray_bin[9] = gray_s_r[9];
        for (int i = 8; i >= 0; i--) begin
            gray_bin[i] = gray_bin[i + 1] ^ gray_s_r[i];
        end
    end

    wire logic              win_end = (win_r == 20'(MEAS_WIN - 1));

    // no range clamp: any rate the receivers lock to is measured and followed
    always_ff @(posedge core_clk) begin
        if (srst) begin
            win_r      <= 20'h00000;
            bin_prev_r <= 10'h000;
            meas_khz_r <= 10'h000;
        end else if (win_end) begin
            win_r      <= 20'h00000;
            bin_prev_r <= gray_bin;
            meas_khz_r <= gray_bin - bin_prev_r;
        end else begin
            win_r      <= win_r + 20'h00001;
        end
    end

    // ------------------------------------------------------------
    // internal rate synthesis
    // ------------------------------------------------------------
    wire logic              dds_on   = cfg_r.dds_en && is_master;
    wire logic [17:0]       xtal_hz  = cfg_r.fam_48k ? sss_pkg::XTAL_48K_HZ
                                                     : sss_pkg::XTAL_44K1_HZ;
    wire logic signed [21:0] crs     = cfg_r.coarse_en ? 22'(cfg_r.coarse_hz) : 22'sh0;
    wire logic signed [21:0] fin     = cfg_r.fine_en ? 22'(cfg_r.fine_hz) : 22'sh0;
    wire logic signed [21:0] adj     = $signed({4'h0, cfg_r.dds_base_hz}) + crs + fin;
    wire logic [20:0]       adj_u    = adj[21] ? 21'h000000 : adj[20:0];
    wire logic [20:0]       dev_s    = adj_u / sss_pkg::PULL_SMALL_DIV;
    wire logic [20:0]       dev_l    = adj_u / sss_pkg::PULL_LARGE_DIV;
    logic [20:0]            pulled;

    always_comb begin
        unique case (cfg_r.pull)
            sss_pkg::PULL_UP_SMALL: pulled = adj_u + dev_s;
            sss_pkg::PULL_DN_SMALL: pulled = adj_u - dev_s;
            sss_pkg::PULL_UP_LARGE: pulled = adj_u + dev_l;
            sss_pkg::PULL_DN_LARGE: pulled = adj_u - dev_l;
            default:                pulled = adj_u;
        endcase
    end

    wire logic [20:0]       base_hz  = dds_on ? pulled : {3'h0, xtal_hz};
    wire logic [22:0]       rate_nxt = (cfg_r.mult == sss_pkg::MULT_QUAD)   ? {base_hz, 2'h0} :
                                       (cfg_r.mult == sss_pkg::MULT_DOUBLE) ? {1'h0, base_hz, 1'h0}
                                                                            : {2'h0, base_hz};
    wire logic [9:0]        int_khz  = 10'(rate_nxt / sss_pkg::HZ_PER_KHZ);

    // ------------------------------------------------------------
    // multiplex, bandwidth and status
    // ------------------------------------------------------------
    wire logic              pref_opt = (cfg_r.pref_src == sss_pkg::SRC_OPT1) ||
                                       (cfg_r.pref_src == sss_pkg::SRC_OPT2);
    wire logic              act_opt  = (clk_sel_r == sss_pkg::SRC_OPT1) ||
                                       (clk_sel_r == sss_pkg::SRC_OPT2);
    wire logic              smux_nxt = cfg_r.auto_mode && pref_opt &&
                                       (cfg_r.mult == sss_pkg::MULT_DOUBLE);
    // optical frames stay at single speed, so the system rate is twice the frame rate
    wire logic [9:0]        sys_khz  = is_master ? int_khz :
                                       (smux_nxt && act_opt) ? {meas_khz_r[8:0], 1'b0}
                                                             : meas_khz_r;
    wire logic [9:0]        opt_nxt  = smux_nxt ? {1'b0, sys_khz[9:1]} : sys_khz;
    logic [27:0]            chan_nxt;

    always_comb begin
        unique case (cfg_r.bw)
            sss_pkg::BW_NO_OPT2:   chan_nxt = 28'((64'h1 << sss_pkg::CH_NO_OPT2) - 64'h1);
            sss_pkg::BW_ANA_SPDIF: chan_nxt = 28'((64'h1 << sss_pkg::CH_ANA_SPDIF) - 64'h1);
            sss_pkg::BW_ANA8:      chan_nxt = 28'((64'h1 << sss_pkg::CH_ANA8) - 64'h1);
            default:               chan_nxt = 28'((64'h1 << sss_pkg::CH_ALL) - 64'h1);
        endcase
    end

    sss_pkg::sss_stat_type  stat_nxt;
    assign stat_nxt.wc    = in_state(lock_s_r[0], sync_s_r[0]);
    assign stat_nxt.opt1  = in_state(lock_s_r[1], sync_s_r[1]);
    assign stat_nxt.opt2  = in_state(lock_s_r[2], sync_s_r[2]);
    assign stat_nxt.spdif = in_state(lock_s_r[3], sync_s_r[3]);

    logic                   slave_r;
    logic [2:0]             act_src_r;
    logic [9:0]             act_khz_r;
    sss_pkg::sss_stat_type  stat_r;
    logic                   smux_r;
    logic [9:0]             opt_khz_r;
    logic [21:0]            rate_r;
    logic [27:0]            chan_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            slave_r   <= 1'b0;
            act_src_r <= sss_pkg::SRC_INT;
            act_khz_r <= 10'h000;
            stat_r    <= '0;
            smux_r    <= 1'b0;
            opt_khz_r <= 10'h000;
            rate_r    <= 22'h000000;
            chan_r    <= 28'h0000000;
        end else begin
            slave_r   <= !is_master;
            act_src_r <= clk_sel_r;
            act_khz_r <= sys_khz;
            stat_r    <= stat_nxt;
            smux_r    <= smux_nxt;
            opt_khz_r <= opt_nxt;
            rate_r    <= rate_nxt[21:0];
            chan_r    <= chan_nxt;
        end
    end

    assign clk_sel     = clk_sel_r;
    assign clk_gate_en = gate_r;
    assign slave       = slave_r;
    assign active_src  = act_src_r;
    assign active_khz  = act_khz_r;
    assign sync_stat   = stat_r;
    assign smux_mode   = smux_r;
    assign opt_khz     = opt_khz_r;
    assign int_rate_hz = rate_r;
    assign chan_en     = chan_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    fall_back_a: assert property (!cfg_r.auto_mode && !is_master && sw_r != SW_GUARD
        |=> !gate_r) else $error("master mode not restored");
    none_master_a: assert property ((valid == 6'h00) && sw_r == SW_SLAVE
        |=> sw_r == SW_GUARD && pend_r == sss_pkg::SRC_INT) else $error("no fallback");
    pref_pick_a: assert property (cfg_r.auto_mode && pref_ok |-> pick == cfg_r.pref_src)
        else $error("preferred input ignored");
    first_pick_a: assert property (cfg_r.auto_mode && !pref_ok && valid[0] |-> pick == 3'h1)
        else $error("first valid input not taken");
    gate_hold_a: assert property ($fell(gate_r) |-> !gate_r [*8])
        else $error("gate reopened early");
    sel_stable_a: assert property (gate_r && $past(gate_r) |-> $stable(clk_sel_r))
        else $error("select moved with gate open");
    slave_rep_a: assert property (##1 slave_r == !$past(is_master))
        else $error("slave report wrong");
    src_rep_a: assert property (##1 act_src_r == $past(clk_sel_r))
        else $error("active source report wrong");
    dds_gate_a: assert property (!cfg_r.dds_en |-> base_hz == {3'h0, xtal_hz})
        else $error("synth setting leaked");
    smux_half_a: assert property (smux_r |-> opt_khz_r == {1'b0, act_khz_r[9:1]})
        else $error("optical rate not half");
    bw_drop_a: assert property (cfg_r.bw == sss_pkg::BW_NO_OPT2 |=> chan_r[27:20] == 8'h00)
        else $error("optical two channels active");
    tco_gate_a: assert property (!tco_s_r |-> valid[5:4] == 2'h0)
        else $error("timecode input used without module");

    to_slave_c:  cover property (sw_r == SW_GUARD ##1 sw_r == SW_SLAVE);
    to_master_c: cover property (sw_r == SW_SLAVE ##[1:40] sw_r == SW_MASTER);
    smux_c:      cover property ($rose(smux_r));
    nv_load_c:   cover property (!nv_done_r && nv_ready);
endmodule
`default_nettype wire

// ===== verif/sss_ext_src.sv
// far-side model: external gear giving lock/sync levels and a frame clock
// assumes the bench sets lock_req, sync_req and run
`timescale 1ns/100ps
`default_nettype none
module sss_ext_src (
    input  wire logic       run,        // clock present
    input  wire logic [5:0] lock_req,   // lock per input
    input  wire logic [5:0] sync_req,   // sync per input
    output logic            link_clk,   // 15 ns, stands still when idle
    output logic            frame_tick, // every other link cycle
    output logic [5:0]      in_lock,    // lock pins
    output logic [5:0]      in_sync     // sync pins
);
    logic tick_r;
    assign in_lock    = lock_req;
    assign in_sync    = sync_req & lock_req;
    // no stale tick while the link is stopped
    assign frame_tick = tick_r & run;
    initial begin
        link_clk = 1'b0;
        tick_r   = 1'b0;
        #3.1;
        forever begin
            #7.5;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end
    always @(posedge link_clk) begin
        tick_r <= ~tick_r;
    end
endmodule
`default_nettype wire

// ===== verif/sync_source_selector_tb.sv
// bench: settings, pin stimulus and report checks of the selector
// assumes the far-side model above; 1 us measuring window
`timescale 1ns/100ps
`default_nettype none
module sync_source_selector_tb;
    logic                  core_clk, srst, host_cfg_wr, nv_ready, tco_fitted, run;
    logic                  link_clk, frame_tick, clk_gate_en, slave, smux_mode;
    logic [5:0]            lock_req, sync_req, in_lock, in_sync;
    logic [2:0]            clk_sel, active_src;
    logic [9:0]            active_khz, opt_khz;
    logic [21:0]           int_rate_hz;
    logic [27:0]           chan_en;
    sss_pkg::sss_stat_type sync_stat;
    sss_pkg::sss_cfg_type  host_cfg, nv_cfg, cfg;
    int                    error_cnt, total_checks, p;
    logic [27:0]           bw_exp [4] = '{28'hFFFFFFF, 28'h00FFFFF, 28'h0000FFF, 28'h00000FF};
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    sss_selector #(.MEAS_WIN(250)) u_dut (.core_clk(core_clk), .srst(srst),
        .link_clk(link_clk), .frame_tick(frame_tick), .in_lock(in_lock), .in_sync(in_sync),
        .tco_fitted(tco_fitted), .host_cfg(host_cfg), .host_cfg_wr(host_cfg_wr),
        .nv_cfg(nv_cfg), .nv_ready(nv_ready), .clk_sel(clk_sel), .clk_gate_en(clk_gate_en),
        .slave(slave), .active_src(active_src), .active_khz(active_khz),
        .sync_stat(sync_stat), .smux_mode(smux_mode), .opt_khz(opt_khz),
        .int_rate_hz(int_rate_hz), .chan_en(chan_en));
    sss_ext_src u_src (.run(run), .lock_req(lock_req), .sync_req(sync_req),
        .link_clk(link_clk), .frame_tick(frame_tick), .in_lock(in_lock), .in_sync(in_sync));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task put(input sss_pkg::sss_cfg_type c);
        @(negedge core_clk);
        host_cfg    = c;
        host_cfg_wr = 1'b1;
        @(negedge core_clk);
        host_cfg_wr = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask
    // 20 cycles covers 2 sync flops, the 10-cycle guard and the report lag
    task pins(input logic [5:0] l, input logic [5:0] s);
        @(negedge core_clk);
        lock_req = l;
        sync_req = s;
        run      = |l;
        repeat (20) @(negedge core_clk);
    endtask
    task src(input logic [2:0] a, input logic sl);
        check("active_src", 32'(active_src), 32'(a));
        check("slave", 32'(slave), 32'(sl));
    endtask
    function automatic int rate(input int b, input int pl);
        case (pl)
            1: return b + b / 1000;
            2: return b - b / 1000;
            3: return b + b / 25;
            4: return b - b / 25;
            default: return b;
        endcase
    endfunction
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        complete_run;
    end
    initial begin
        {srst, run, nv_ready} = 3'h7;
        {host_cfg_wr, tco_fitted, lock_req, sync_req, error_cnt, total_checks} = '0;
        host_cfg = '0;
        cfg = '0;
        nv_cfg = '0;
        nv_cfg.bw = sss_pkg::BW_ANA8;
        nv_cfg.fam_48k = 1'b1;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        repeat (4) @(negedge core_clk);
        check("chan_en nv", 32'(chan_en), 32'h000000FF);
        check("rate nv", 32'(int_rate_hz), 32'h0000BB80);
        for (p = 0; p < 4; p++) begin
            cfg.bw = sss_pkg::sss_bw_type'(p);
            put(cfg);
            check("chan_en", 32'(chan_en), 32'(bw_exp[p]));
        end
        $display("test bandwidth done");
        cfg.dds_en = 1'b1;
        cfg.dds_base_hz = 18'h0BB80;
        {cfg.coarse_en, cfg.coarse_hz, cfg.fine_hz} = {1'b1, 16'sh0064, 16'sh0007};
        cfg.mult = sss_pkg::MULT_DOUBLE;
        for (p = 0; p < 5; p++) begin
            cfg.pull = sss_pkg::sss_pull_type'(p);
            put(cfg);
            check("rate", 32'(int_rate_hz), 32'(rate(48100, p) * 2));
        end
        cfg.fine_en = 1'b1;
        cfg.mult = sss_pkg::MULT_QUAD;
        put(cfg);
        check("rate fine", 32'(int_rate_hz), 32'(rate(48107, 4) * 4));
        cfg.dds_en = 1'b0;
        put(cfg);
        check("rate off", 32'(int_rate_hz), 32'h0002B110);
        $display("test synthesis done");
        {cfg.dds_en, cfg.auto_mode, cfg.pref_src} = {2'h3, sss_pkg::SRC_OPT2};
        cfg.mult = sss_pkg::MULT_SINGLE;
        put(cfg);
        pins(6'h0A, 6'h08);
        src(sss_pkg::SRC_OPT1, 1'b1);
        check("sync_stat", 32'(sync_stat), 32'h00000012);
        check("rate slave", 32'(int_rate_hz), 32'h0000AC44);
        pins(6'h0E, 6'h00);
        src(sss_pkg::SRC_OPT2, 1'b1);
        pins(6'h00, 6'h00);
        src(sss_pkg::SRC_INT, 1'b0);
        pins(6'h10, 6'h00);
        src(sss_pkg::SRC_INT, 1'b0);
        tco_fitted = 1'b1;
        pins(6'h10, 6'h00);
        src(sss_pkg::SRC_TC, 1'b1);
        $display("test selection done");
        pins(6'h01, 6'h01);
        repeat (600) @(negedge core_clk);
        src(sss_pkg::SRC_WC, 1'b1);
        check("khz", 32'(active_khz >= 32 && active_khz <= 35), 32'h1);
        cfg.pref_src = sss_pkg::SRC_OPT1;
        cfg.mult = sss_pkg::MULT_DOUBLE;
        put(cfg);
        pins(6'h02, 6'h00);
        repeat (600) @(negedge core_clk);
        check("smux", 32'(smux_mode), 32'h1);
        check("opt khz", 32'(opt_khz >= 32 && opt_khz <= 35), 32'h1);
        check("sys khz", 32'(active_khz >= 64 && active_khz <= 70), 32'h1);
        $display("test frequency done");
        cfg.auto_mode = 1'b0;
        put(cfg);
        repeat (20) @(negedge core_clk);
        src(sss_pkg::SRC_INT, 1'b0);
        check("smux off", 32'(smux_mode), 32'h0);
        $display("test manual master done");
        complete_run;
    end
endmodule
`default_nettype wire
